// ---- logic/io_config_and_readback_regs.sv ----
// I/O configuration, converter write and readback register group
`timescale 1ns/100ps
`default_nettype none

module io_config_and_readback_regs #(
  parameter int PINS   = io_regs_pkg::PINS,
  parameter int CODE_W = io_regs_pkg::CODE_W
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [3:0]             i_reg_addr,
  input  wire logic [2:0]             i_reg_chan,
  input  wire logic [15:0]            i_reg_wdata,
  output var  logic [15:0]            o_reg_rdata,
  output var  logic                   o_reg_rvalid,
  input  wire logic                   i_conv_valid,
  input  wire logic                   i_conv_is_temp,
  input  wire logic [2:0]             i_conv_chan,
  input  wire logic [CODE_W-1:0]      i_conv_data,
  input  wire logic [PINS-1:0]        i_pin_is_output,
  input  wire logic [PINS-1:0]        i_pin_is_input,
  input  wire logic [PINS-1:0]        i_pin_in,
  output var  logic [PINS-1:0]        o_pin_out,
  output var  logic [PINS-1:0]        o_pin_oe,
  output var  logic [PINS*CODE_W-1:0] o_chan_code,
  output var  logic                   o_soft_reset
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [PINS-1:0]   output_drive_select;
  logic [PINS-1:0]   pin_three_state_select;
  logic [PINS-1:0]   gpio_output_level;
  logic [CODE_W-1:0] chan_reg [PINS];
  logic [2:0]        result_chan;
  logic [CODE_W-1:0] result_code;
  logic [CODE_W-1:0] temp_code;

  // ==========================================================================
  // Write decode
  // ==========================================================================
  wire logic        wr_drive   = i_reg_wr && (i_reg_addr == io_regs_pkg::ADDR_OUTPUT_DRIVE);
  wire logic        wr_ts      = i_reg_wr && (i_reg_addr == io_regs_pkg::ADDR_THREE_STATE);
  wire logic        wr_level   = i_reg_wr && (i_reg_addr == io_regs_pkg::ADDR_GPIO_LEVEL);
  wire logic        wr_conv    = i_reg_wr && (i_reg_addr == io_regs_pkg::ADDR_CONVERTER_WRITE);
  wire logic        wr_soft    = i_reg_wr && (i_reg_addr == io_regs_pkg::ADDR_SOFT_RESET);
  // Only the exact key in the low 11 bits is honoured (upper bits ignored); anything else is dropped silently
  wire logic        key_match  = wr_soft && (i_reg_wdata[io_regs_pkg::KEY_W-1:0] == io_regs_pkg::RESET_KEY);
  wire logic [15:0] next_rdata;

  // Soft reset is taken one cycle after the key write and wins over any register write
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_soft_reset <= 1'b0;
    else       o_soft_reset <= key_match;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      output_drive_select    <= io_regs_pkg::PIN_RESET;
      pin_three_state_select <= io_regs_pkg::PIN_RESET;
      gpio_output_level      <= io_regs_pkg::PIN_RESET;
    end else if (o_soft_reset) begin
      output_drive_select    <= io_regs_pkg::PIN_RESET;
      pin_three_state_select <= io_regs_pkg::PIN_RESET;
      gpio_output_level      <= io_regs_pkg::PIN_RESET;
    end else begin
      if (wr_drive) output_drive_select    <= i_reg_wdata[PINS-1:0];
      if (wr_ts)    pin_three_state_select <= i_reg_wdata[PINS-1:0];
      if (wr_level) gpio_output_level      <= i_reg_wdata[PINS-1:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < PINS; k++) chan_reg[k] <= io_regs_pkg::CODE_RESET;
    end else if (o_soft_reset) begin
      for (int k = 0; k < PINS; k++) chan_reg[k] <= io_regs_pkg::CODE_RESET;
    end else if (wr_conv) begin
      chan_reg[i_reg_chan] <= i_reg_wdata[CODE_W-1:0];
    end
  end

  // Results come from the converter side; the latest one of each kind is held
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      result_chan <= io_regs_pkg::CHAN_RESET;
      result_code <= io_regs_pkg::CODE_RESET;
      temp_code   <= io_regs_pkg::CODE_RESET;
    end else if (o_soft_reset) begin
      result_chan <= io_regs_pkg::CHAN_RESET;
      result_code <= io_regs_pkg::CODE_RESET;
      temp_code   <= io_regs_pkg::CODE_RESET;
    end else if (i_conv_valid && i_conv_is_temp) begin
      temp_code   <= i_conv_data;
    end else if (i_conv_valid) begin
      result_chan <= i_conv_chan;
      result_code <= i_conv_data;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  wire logic [15:0] rb_word   = {io_regs_pkg::READBACK_MSB, i_reg_chan, chan_reg[i_reg_chan]};
  wire logic [15:0] res_word  = {io_regs_pkg::RESULT_MSB, result_chan, result_code};
  wire logic [15:0] temp_word = {io_regs_pkg::TEMP_TAG, temp_code};
  // Pins not set as inputs read zero rather than whatever sits on the pad
  wire logic [15:0] gpi_word  = {{(16-PINS){1'b0}}, i_pin_in & i_pin_is_input};
  wire logic [15:0] drv_word  = {{(16-PINS){1'b0}}, output_drive_select};
  wire logic [15:0] ts_word   = {{(16-PINS){1'b0}}, pin_three_state_select};
  wire logic [15:0] lvl_word  = {{(16-PINS){1'b0}}, gpio_output_level};

  assign next_rdata = (i_reg_addr == io_regs_pkg::ADDR_OUTPUT_READBACK)   ? rb_word   :
                      (i_reg_addr == io_regs_pkg::ADDR_CONVERSION_RESULT) ? res_word  :
                      (i_reg_addr == io_regs_pkg::ADDR_TEMPERATURE)       ? temp_word :
                      (i_reg_addr == io_regs_pkg::ADDR_GPIO_INPUT)        ? gpi_word  :
                      (i_reg_addr == io_regs_pkg::ADDR_OUTPUT_DRIVE)      ? drv_word  :
                      (i_reg_addr == io_regs_pkg::ADDR_THREE_STATE)       ? ts_word   :
                      (i_reg_addr == io_regs_pkg::ADDR_GPIO_LEVEL)        ? lvl_word  :
                      io_regs_pkg::WORD_ZERO;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata  <= io_regs_pkg::WORD_ZERO;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rdata  <= i_reg_rd ? next_rdata : io_regs_pkg::WORD_ZERO;
      o_reg_rvalid <= i_reg_rd;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_chan_code <= '0;
    end else begin
      for (int k = 0; k < PINS; k++) o_chan_code[k*CODE_W +: CODE_W] <= chan_reg[k];
    end
  end

  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  // Drive selection only takes effect on pins the pin-mode setup made outputs
  for (genvar g = 0; g < PINS; g++) begin : g_pin
    pin_drive_cell u_cell (
      .i_clk         (i_clk),
      .i_rst         (i_rst),
      .i_is_output   (i_pin_is_output[g]),
      .i_open_drain  (output_drive_select[g]),
      .i_three_state (pin_three_state_select[g]),
      .i_level       (gpio_output_level[g]),
      .o_out         (o_pin_out[g]),
      .o_oe          (o_pin_oe[g])
    );
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // An open-drain pin may only be driven while its level is low, and then only low
  od_no_high_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ((o_pin_oe & $past(output_drive_select) & ($past(gpio_output_level) | o_pin_out)) == '0))
    else $error("open-drain pin driven high");

  ts_float_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ((o_pin_oe & $past(pin_three_state_select)) == '0))
    else $error("three-state pin is driven");

  reserved_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reg_rd && (i_reg_addr == io_regs_pkg::ADDR_OUTPUT_DRIVE || i_reg_addr == io_regs_pkg::ADDR_THREE_STATE)
    |=> o_reg_rvalid && (o_reg_rdata[15:8] == 8'h00))
    else $error("reserved upper bits not zero");

  key_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
    key_match |=> o_soft_reset ##1 (output_drive_select == '0 && pin_three_state_select == '0 && chan_reg[0] == '0))
    else $error("keyed reset did not clear registers");

  bad_key_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_soft && (i_reg_wdata[10:0] != io_regs_pkg::RESET_KEY) |=> !o_soft_reset)
    else $error("non-key write caused reset");

  chan_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_conv && !o_soft_reset |=> chan_reg[$past(i_reg_chan)] == $past(i_reg_wdata[11:0]))
    else $error("converter write not loaded");

  readback_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reg_rd && i_reg_addr == io_regs_pkg::ADDR_OUTPUT_READBACK
    |=> o_reg_rdata[15] && o_reg_rdata[14:12] == $past(i_reg_chan))
    else $error("readback word tag wrong");

  result_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_conv_valid && !i_conv_is_temp && !o_soft_reset ##1 i_reg_rd && i_reg_addr == io_regs_pkg::ADDR_CONVERSION_RESULT
    && !i_conv_valid && !o_soft_reset |=> o_reg_rdata == {1'b0, $past(i_conv_chan, 2), $past(i_conv_data, 2)})
    else $error("conversion result word wrong");

  temp_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reg_rd && i_reg_addr == io_regs_pkg::ADDR_TEMPERATURE |=> o_reg_rdata[15:12] == 4'h8)
    else $error("temperature tag wrong");

  gpio_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reg_rd && i_reg_addr == io_regs_pkg::ADDR_GPIO_INPUT |=> o_reg_rdata == {8'h00, $past(i_pin_in & i_pin_is_input)})
    else $error("gpio input readback wrong");

  soft_reset_c:  cover property (@(posedge i_clk) disable iff (i_rst) key_match ##1 o_soft_reset);
  open_drain_c:  cover property (@(posedge i_clk) disable iff (i_rst) |(o_pin_oe & ~o_pin_out & output_drive_select));
  readback_c:    cover property (@(posedge i_clk) disable iff (i_rst)
    wr_conv ##[1:3] i_reg_rd && i_reg_addr == io_regs_pkg::ADDR_OUTPUT_READBACK);

endmodule : io_config_and_readback_regs

`default_nettype wire

// ---- logic/io_regs_pkg.sv ----
// Package: register pointers, field layouts, reset values and tags of the I/O register group
package io_regs_pkg;

  // ==========================================================================
  // Register pointers
  // ==========================================================================
  localparam logic [3:0] ADDR_CONVERTER_WRITE   = 4'h0;
  localparam logic [3:0] ADDR_OUTPUT_READBACK   = 4'h1;
  localparam logic [3:0] ADDR_CONVERSION_RESULT = 4'h2;
  localparam logic [3:0] ADDR_TEMPERATURE       = 4'h3;
  localparam logic [3:0] ADDR_GPIO_LEVEL        = 4'h4;
  localparam logic [3:0] ADDR_GPIO_INPUT        = 4'h5;
  localparam logic [3:0] ADDR_OUTPUT_DRIVE      = 4'h6;
  localparam logic [3:0] ADDR_THREE_STATE       = 4'h7;
  localparam logic [3:0] ADDR_SOFT_RESET        = 4'h8;

  // ==========================================================================
  // Field layouts and values
  // ==========================================================================
  localparam int          WORD_W       = 16;
  localparam int          PINS         = 8;
  localparam int          CODE_W       = 12;
  localparam int          CHAN_W       = 3;
  localparam int          KEY_W        = 11;
  localparam int          TAG_W        = 4;
  localparam logic [10:0] RESET_KEY    = 11'h5AC;
  localparam logic [0:0]  READBACK_MSB = 1'h1;
  localparam logic [0:0]  RESULT_MSB   = 1'h0;
  localparam logic [3:0]  TEMP_TAG     = 4'h8;
  localparam logic [7:0]  PIN_RESET    = 8'h00;
  localparam logic [11:0] CODE_RESET   = 12'h000;
  localparam logic [2:0]  CHAN_RESET   = 3'h0;
  localparam logic [15:0] WORD_ZERO    = 16'h0000;

endpackage : io_regs_pkg

// ---- logic/pin_drive_cell.sv ----
// Per-pin output driver: three-state, open-drain and push/pull selection
`timescale 1ns/100ps
`default_nettype none

module pin_drive_cell (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_is_output,
  input  wire logic i_open_drain,
  input  wire logic i_three_state,
  input  wire logic i_level,
  output var  logic o_out,
  output var  logic o_oe
);

  // ==========================================================================
  // Drive decision
  // ==========================================================================
  // Open-drain only ever pulls low; a high level releases the pin
  wire logic drive_en   = !i_three_state && i_is_output && (!i_open_drain || !i_level);
  wire logic drive_bit  = i_open_drain ? 1'b0 : i_level;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_out <= 1'b0;
      o_oe  <= 1'b0;
    end else begin
      o_out <= drive_bit;
      o_oe  <= drive_en;
    end
  end

endmodule : pin_drive_cell

`default_nettype wire

// ---- test/host_model.sv ----
// Behavioural serial-bus host that issues register writes and reads to the I/O register group
`timescale 1ns/100ps
`default_nettype none

module host_model (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_reg_rdata,
  input  wire logic        i_reg_rvalid,
  output var  logic        o_reg_wr,
  output var  logic        o_reg_rd,
  output var  logic [3:0]  o_reg_addr,
  output var  logic [2:0]  o_reg_chan,
  output var  logic [15:0] o_reg_wdata
);
  initial begin
    {o_reg_wr, o_reg_rd, o_reg_addr, o_reg_chan, o_reg_wdata} = '0;
  end

  // ==========================================================================
  // Bus cycles: strobe raised at a falling edge, dropped one cycle later
  // ==========================================================================
  task automatic write_reg(input logic [3:0] addr, input logic [2:0] chan, input logic [15:0] data);
    @(negedge i_clk);
    {o_reg_wr, o_reg_addr, o_reg_chan, o_reg_wdata} = {1'h1, addr, chan, data};
    @(negedge i_clk);
    o_reg_wr = 1'h0;
  endtask : write_reg

  task automatic read_reg(input logic [3:0] addr, input logic [2:0] chan, output logic [15:0] data,
                          output logic valid);
    @(negedge i_clk);
    {o_reg_rd, o_reg_addr, o_reg_chan} = {1'h1, addr, chan};
    @(negedge i_clk);
    o_reg_rd = 1'h0;
    // Answer stands one cycle only, so it is taken here
    data  = i_reg_rdata;
    valid = i_reg_rvalid;
  endtask : read_reg
endmodule : host_model
`default_nettype wire

// ---- test/tb_io_config_and_readback_regs.sv ----
// Self-checking testbench of the I/O configuration and readback register group
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module tb_io_config_and_readback_regs;
  logic        clk, rst, wr, rd, rvalid, conv_valid, conv_is_temp, soft_reset;
  logic [3:0]  addr;
  logic [2:0]  chan, conv_chan;
  logic [15:0] wdata, rdata;
  logic [11:0] conv_data;
  logic [7:0]  is_out, is_in, pin_in, pin_out, pin_oe;
  logic [95:0] chan_code;
  int          errors, comparisons;

  io_config_and_readback_regs DUT (.i_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_chan(chan), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_conv_valid(conv_valid), .i_conv_is_temp(conv_is_temp), .i_conv_chan(conv_chan), .i_conv_data(conv_data),
    .i_pin_is_output(is_out), .i_pin_is_input(is_in), .i_pin_in(pin_in), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_chan_code(chan_code), .o_soft_reset(soft_reset));

  host_model host (.i_clk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_addr(addr), .o_reg_chan(chan), .o_reg_wdata(wdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic rd_chk(input logic [3:0] a, input logic [2:0] c, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    host.read_reg(a, c, d, v);
    `CHK("rvalid", 1'h1, v)
    `CHK("rdata", exp, d)
  endtask : rd_chk

  // Pins follow the registers one cycle late
  task automatic pins_chk(input logic [7:0] lvl, input logic [7:0] od, input logic [7:0] ts);
    repeat (2) @(negedge clk);
    `CHK("pin_out", lvl & ~od, pin_out)
    `CHK("pin_oe", ~ts & is_out & (~od | ~lvl), pin_oe)
  endtask : pins_chk

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic reset_values();
    rd_chk(io_regs_pkg::ADDR_OUTPUT_DRIVE, 3'h0, 16'h0000);
    rd_chk(io_regs_pkg::ADDR_THREE_STATE, 3'h0, 16'h0000);
    rd_chk(io_regs_pkg::ADDR_OUTPUT_READBACK, 3'h7, 16'hF000);
    rd_chk(4'hF, 3'h0, 16'h0000);
    `CHK("oe_reset", 8'h00, pin_oe)
  endtask : reset_values

  task automatic drive_and_float();
    // Pins declared outputs first, so drive selection means something
    is_out = 8'hFF;
    host.write_reg(io_regs_pkg::ADDR_GPIO_LEVEL, 3'h0, 16'h00A5);
    host.write_reg(io_regs_pkg::ADDR_OUTPUT_DRIVE, 3'h0, 16'hFF0F);
    rd_chk(io_regs_pkg::ADDR_OUTPUT_DRIVE, 3'h0, 16'h000F);
    pins_chk(8'hA5, 8'h0F, 8'h00);
    host.write_reg(io_regs_pkg::ADDR_THREE_STATE, 3'h0, 16'hFF3C);
    rd_chk(io_regs_pkg::ADDR_THREE_STATE, 3'h0, 16'h003C);
    pins_chk(8'hA5, 8'h0F, 8'h3C);
  endtask : drive_and_float

  task automatic converter_channels();
    for (int k = 0; k < 8; k++) begin
      host.write_reg(io_regs_pkg::ADDR_CONVERTER_WRITE, 3'(k), {4'hF, 12'(16'h0A50 + k)});
    end
    for (int k = 0; k < 8; k++) begin
      rd_chk(io_regs_pkg::ADDR_OUTPUT_READBACK, 3'(k), {1'h1, 3'(k), 12'(16'h0A50 + k)});
      `CHK("chan_code", 12'(16'h0A50 + k), chan_code[12*k +: 12])
    end
  endtask : converter_channels

  task automatic conversion_results();
    @(negedge clk);
    {conv_valid, conv_is_temp, conv_chan, conv_data} = {1'h1, 1'h1, 3'h2, 12'h123};
    @(negedge clk);
    {conv_is_temp, conv_chan, conv_data} = {1'h0, 3'h5, 12'hABC};
    // Read issued the very cycle after the result is taken, as the converter side allows
    fork
      rd_chk(io_regs_pkg::ADDR_CONVERSION_RESULT, 3'h0, 16'h5ABC);
      begin
        @(negedge clk);
        conv_valid = 1'h0;
      end
    join
    rd_chk(io_regs_pkg::ADDR_TEMPERATURE, 3'h0, 16'h8123);
    {is_in, pin_in} = {8'h0F, 8'hC3};
    rd_chk(io_regs_pkg::ADDR_GPIO_INPUT, 3'h0, 16'h0003);
  endtask : conversion_results

  task automatic keyed_reset();
    host.write_reg(io_regs_pkg::ADDR_SOFT_RESET, 3'h0, 16'h05AD);
    `CHK("soft_reset_nokey", 1'h0, soft_reset)
    rd_chk(io_regs_pkg::ADDR_OUTPUT_DRIVE, 3'h0, 16'h000F);
    host.write_reg(io_regs_pkg::ADDR_SOFT_RESET, 3'h0, 16'h05AC);
    `CHK("soft_reset_key", 1'h1, soft_reset)
    @(negedge clk);
    `CHK("soft_reset_end", 1'h0, soft_reset)
    rd_chk(io_regs_pkg::ADDR_OUTPUT_DRIVE, 3'h0, 16'h0000);
    rd_chk(io_regs_pkg::ADDR_THREE_STATE, 3'h0, 16'h0000);
    rd_chk(io_regs_pkg::ADDR_OUTPUT_READBACK, 3'h2, 16'hA000);
    rd_chk(io_regs_pkg::ADDR_CONVERSION_RESULT, 3'h0, 16'h0000);
    rd_chk(io_regs_pkg::ADDR_TEMPERATURE, 3'h0, 16'h8000);
    rd_chk(io_regs_pkg::ADDR_SOFT_RESET, 3'h0, 16'h0000);
    `CHK("chan_code_clr", 96'h0, chan_code)
  endtask : keyed_reset

  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    {errors, comparisons} = '0;
    rst = 1'b1;
    {conv_valid, conv_is_temp, conv_chan, conv_data, is_out, is_in, pin_in} = '0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    reset_values();
    drive_and_float();
    converter_channels();
    conversion_results();
    keyed_reset();
    report_and_stop();
  end

  // Whole sequence needs well under 200 cycles
  initial begin
    #20000;
    errors++;
    report_and_stop();
  end
endmodule : tb_io_config_and_readback_regs
`default_nettype wire
